// [inc/pioc_cfg.svh]
`ifndef PIOC_CFG_SVH
`define PIOC_CFG_SVH
// Data-memory byte addresses of the port locations
`define PIOC_ADDR_L_DATA 8'h00
`define PIOC_ADDR_L_CFG 8'h01
`define PIOC_ADDR_L_PIN 8'h02
`define PIOC_ADDR_G_DATA 8'h03
`define PIOC_ADDR_G_CFG 8'h04
`define PIOC_ADDR_G_PIN 8'h05
`define PIOC_ADDR_D_DATA 8'h06
`define PIOC_ADDR_CTRL 8'h07
// Field positions
`define PIOC_G_HALT_BIT 7
`define PIOC_G_IDLE_BIT 6
`define PIOC_G_ALTSK_BIT 6
`define PIOC_G_SO_BIT 4
`define PIOC_G_SK_BIT 5
`define PIOC_G_TIO_BIT 3
`define PIOC_CTRL_SEL_BIT 3
`define PIOC_L_PWM_CHANNEL_ONE_BIT 5
`define PIOC_L_PWM_CHANNEL_ZERO_BIT 6
`define PIOC_L_CMP2_BIT 6
`define PIOC_L_CMP1_BIT 2
// Reset values
`define PIOC_RST_BYTE 8'h00
`define PIOC_RST_D 4'hF
`endif

// [inc/pioc_pkg.sv]
`default_nettype none
package pioc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pioc_bus_t;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } pioc_pad_t;
  // Alternate-function outputs from peripherals
  typedef struct packed {
    logic cmp1_out;
    logic cmp2_out;
    logic pwm_channel_zero;
    logic pwm_channel_zero_en;
    logic pwm_channel_one;
    logic pwm_channel_one_en;
    logic cmp1_en;
    logic cmp2_en;
    logic sk;
    logic so;
    logic tio;
    logic tio_en;
    logic osc_clk;
  } pioc_alt_t;
endpackage
`default_nettype wire

// [src/pioc_pad_cell.sv]
`timescale 1ns/1ns
`default_nettype none
module pioc_pad_cell (
  input wire logic cfg,
  input wire logic data,
  input wire logic alt_en,
  input wire logic alt_val,
  output logic out,
  output logic oe,
  output logic pull
);
  wire logic drive = cfg | alt_en;
  // Alternate function overrides the data bit
  assign oe = drive; // R1 R14
  assign out = alt_en ? alt_val : data; // R14
  assign pull = ~drive & data; // R1
endmodule
`default_nettype wire

// [src/pioc_port_io.sv]
// Operation
// R1: Config/data per pin: 00 hi-Z, 01 pull-up, 10 drive low, 11 drive high.
// R2: Each bidirectional port has config, data and read-only pin locations.
// R3: Wake port is seven Schmitt inputs, each a wake-up source.
// R4: Mixed port: bits 0-5 I/O, bit 6 input only, bit 7 clock out.
// R5: Writing one to mixed data bit 7 enters HALT.
// R6: Writing one to mixed data bit 6 enters IDLE.
// R7: Mixed data reads return zero in bits 6 and 7.
// R8: Mixed config bit 6 selects alternate serial clock phase.
// R9: Output-only port is four bits, driven high during reset.
// R10: Wake port bits 6..0 carry comparator, PWM and capture functions; the code uses bits 6, 5 and 2 only.
// R11: Mixed port bits carry serial, timer and interrupt functions.
// R12: Reset clears wake and mixed port registers, pins float; mixed bit 7 still drives the clock out.
// R13: Mixed bits 5 and 4 serve serial only when select bit set.
// R14: Enabled alternate output drives pin instead of data bit.
`timescale 1ns/1ns
`default_nettype none
`include "pioc_cfg.svh"
module pioc_port_io (
  input wire logic clk,
  input wire logic resetn,
  input wire pioc_pkg::pioc_bus_t bus,
  output logic [7:0] rdata,
  input wire logic [6:0] l_pin_in,
  output pioc_pkg::pioc_pad_t l_pad,
  input wire logic [7:0] g_pin_in,
  output pioc_pkg::pioc_pad_t g_pad,
  output logic [3:0] d_out,
  input wire pioc_pkg::pioc_alt_t alt,
  output logic [6:0] multi_input_wakeup,
  output logic halt_req,
  output logic idle_req,
  output logic sk_alt_phase,
  output logic serial_pin_select,
  output logic serial_data_in,
  output logic timer_io_pin,
  output logic timer_capture_pin,
  output logic external_interrupt_pin,
  output logic capture_input_pin
);
  import pioc_pkg::*;

  logic [6:0] l_data_ff, nxt_l_data, l_cfg_ff, nxt_l_cfg;
  logic [7:0] g_data_ff, nxt_g_data, g_cfg_ff, nxt_g_cfg;
  logic [3:0] d_ff, nxt_d;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic halt_ff, idle_ff;
  logic [7:0] rdata_ff;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] k);
    hit = (a == k);
  endfunction

  wire logic wr_l_data = bus.wr & hit(bus.addr, `PIOC_ADDR_L_DATA);
  wire logic wr_l_cfg = bus.wr & hit(bus.addr, `PIOC_ADDR_L_CFG);
  wire logic wr_g_data = bus.wr & hit(bus.addr, `PIOC_ADDR_G_DATA);
  wire logic wr_g_cfg = bus.wr & hit(bus.addr, `PIOC_ADDR_G_CFG);
  wire logic wr_d = bus.wr & hit(bus.addr, `PIOC_ADDR_D_DATA);
  wire logic wr_ctrl = bus.wr & hit(bus.addr, `PIOC_ADDR_CTRL);

  assign nxt_l_data = wr_l_data ? bus.wdata[6:0] : l_data_ff;
  assign nxt_l_cfg = wr_l_cfg ? bus.wdata[6:0] : l_cfg_ff;
  assign nxt_g_data = wr_g_data ? bus.wdata : g_data_ff;
  assign nxt_g_cfg = wr_g_cfg ? bus.wdata : g_cfg_ff;
  assign nxt_d = wr_d ? bus.wdata[3:0] : d_ff;
  assign nxt_ctrl = wr_ctrl ? bus.wdata : ctrl_ff;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      l_data_ff <= 7'h00; // R12
      l_cfg_ff <= 7'h00; // R12
      g_data_ff <= `PIOC_RST_BYTE; // R12
      g_cfg_ff <= `PIOC_RST_BYTE; // R12
      ctrl_ff <= `PIOC_RST_BYTE;
      d_ff <= `PIOC_RST_D; // R9
    end else begin
      l_data_ff <= nxt_l_data;
      l_cfg_ff <= nxt_l_cfg;
      g_data_ff <= nxt_g_data;
      g_cfg_ff <= nxt_g_cfg;
      ctrl_ff <= nxt_ctrl;
      d_ff <= nxt_d;
    end
  end

  // Power modes pulse for one cycle after the write and then clear; reset also clears them
  always_ff @(posedge clk) begin
    if (!resetn) begin
      halt_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else begin
      halt_ff <= wr_g_data & bus.wdata[`PIOC_G_HALT_BIT]; // R5
      idle_ff <= wr_g_data & bus.wdata[`PIOC_G_IDLE_BIT]; // R6
    end
  end
  assign halt_req = halt_ff;
  assign idle_req = idle_ff;

  // Read path; mixed data reads hide the mode bits
  wire logic [7:0] g_data_rd = {2'b00, g_data_ff[5:0]}; // R7
  wire logic [7:0] rd_mux =
    hit(bus.addr, `PIOC_ADDR_L_DATA) ? {1'b0, l_data_ff} :
    hit(bus.addr, `PIOC_ADDR_L_CFG) ? {1'b0, l_cfg_ff} :
    hit(bus.addr, `PIOC_ADDR_L_PIN) ? {1'b0, l_pin_in} : // R2
    hit(bus.addr, `PIOC_ADDR_G_DATA) ? g_data_rd :
    hit(bus.addr, `PIOC_ADDR_G_CFG) ? g_cfg_ff :
    hit(bus.addr, `PIOC_ADDR_G_PIN) ? g_pin_in : // R2
    hit(bus.addr, `PIOC_ADDR_D_DATA) ? {4'h0, d_ff} :
    hit(bus.addr, `PIOC_ADDR_CTRL) ? ctrl_ff : 8'h00;
  always_ff @(posedge clk) begin
    if (!resetn) rdata_ff <= 8'h00;
    else if (bus.rd) rdata_ff <= rd_mux;
  end
  assign rdata = rdata_ff;

  // Output-only port forced high while reset is low
  assign d_out = resetn ? d_ff : `PIOC_RST_D; // R9

  assign serial_pin_select = ctrl_ff[`PIOC_CTRL_SEL_BIT];
  assign sk_alt_phase = g_cfg_ff[`PIOC_G_ALTSK_BIT]; // R8

  // Wake port alternate outputs
  logic [6:0] l_alt_en, l_alt_val;
  assign l_alt_en = {alt.pwm_channel_zero_en | alt.cmp2_en, alt.pwm_channel_one_en, 2'b00,
                     alt.cmp1_en, 2'b00}; // R10
  assign l_alt_val = {alt.pwm_channel_zero_en ? alt.pwm_channel_zero : alt.cmp2_out, alt.pwm_channel_one,
                      2'b00, alt.cmp1_out, 2'b00}; // R10

  // Mixed port: 0..5 I/O, 6 input, 7 clock out
  logic [7:0] g_alt_en, g_alt_val;
  assign g_alt_en = {2'b00, serial_pin_select, serial_pin_select,
                     alt.tio_en, 3'b000}; // R11 R13
  assign g_alt_val = {2'b00, alt.sk, alt.so, alt.tio, 3'b000}; // R11

  logic [6:0] l_o, l_e, l_p;
  logic [5:0] g_o, g_e, g_p;
  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_l
      pioc_pad_cell u_l (
        .cfg(l_cfg_ff[i]), .data(l_data_ff[i]),
        .alt_en(l_alt_en[i]), .alt_val(l_alt_val[i]),
        .out(l_o[i]), .oe(l_e[i]), .pull(l_p[i]));
    end
    for (i = 0; i < 6; i++) begin : g_g
      pioc_pad_cell u_g (
        .cfg(g_cfg_ff[i]), .data(g_data_ff[i]),
        .alt_en(g_alt_en[i]), .alt_val(g_alt_val[i]),
        .out(g_o[i]), .oe(g_e[i]), .pull(g_p[i]));
    end
  endgenerate
  assign l_pad = '{out: {1'b0, l_o}, oe: {1'b0, l_e}, pull: {1'b0, l_p}};
  assign g_pad = '{out: {alt.osc_clk, 1'b0, g_o},
                   oe: {1'b1, 1'b0, g_e},
                   pull: {2'b00, g_p}}; // R4

  // Schmitt-trigger inputs pass straight through, unregistered; all seven wake
  assign multi_input_wakeup = l_pin_in; // R3
  assign capture_input_pin = l_pin_in[`PIOC_L_PWM_CHANNEL_ZERO_BIT]; // R10
  assign serial_data_in = g_pin_in[6]; // R11
  assign timer_io_pin = g_pin_in[`PIOC_G_TIO_BIT]; // R11
  assign timer_capture_pin = g_pin_in[2]; // R11
  assign external_interrupt_pin = g_pin_in[0]; // R11

  chk_halt_write: assert property (@(posedge clk) disable iff (!resetn) // R5
    wr_g_data && bus.wdata[7] |=> halt_req)
    else $error("halt not entered");
  chk_idle_write: assert property (@(posedge clk) disable iff (!resetn) // R6
    wr_g_data && bus.wdata[6] |=> idle_req)
    else $error("idle not entered");
  chk_g_read_top: assert property (@(posedge clk) disable iff (!resetn) // R7
    bus.rd && hit(bus.addr, `PIOC_ADDR_G_DATA) |=> rdata[7:6] == 2'b00)
    else $error("mode bits visible");
  chk_pin_decode: assert property (@(posedge clk) disable iff (!resetn) // R1
    (l_cfg_ff[0] |-> l_pad.oe[0] && l_pad.out[0] == l_data_ff[0]))
    else $error("pin decode wrong");
  chk_pullup_decode: assert property (@(posedge clk) // R1
    disable iff (!resetn)
    !l_cfg_ff[3] && l_data_ff[3] |-> l_pad.pull[3] && !l_pad.oe[3])
    else $error("pull-up wrong");
  chk_d_reset: assert property (@(posedge clk) // R9
    !resetn |-> d_out == 4'hF)
    else $error("d port not high");
  chk_reset_float: assert property (@(posedge clk) // R12
    !resetn |=> g_pad.oe[5:0] == 6'h00 || serial_pin_select)
    else $error("mixed pins drive after reset");
  chk_sk_select: assert property (@(posedge clk) disable iff (!resetn) // R13
    serial_pin_select |-> g_pad.oe[5] && g_pad.out[5] == alt.sk)
    else $error("serial clock not routed");
  chk_alt_phase: assert property (@(posedge clk) disable iff (!resetn) // R8
    wr_g_cfg |=> sk_alt_phase == $past(bus.wdata[6]))
    else $error("phase select wrong");

  // Alternate routing; enables belong to the peripherals, except the serial select, which software sets in the control register
  chk_pwm_channel_zero_route: assert property (@(posedge clk) disable iff (!resetn) // R10
    alt.pwm_channel_zero_en |-> l_pad.oe[6] && l_pad.out[6] == alt.pwm_channel_zero)
    else $error("pwm_channel_zero not routed");
  chk_cmp2_route: assert property (@(posedge clk) disable iff (!resetn) // R10
    alt.cmp2_en && !alt.pwm_channel_zero_en |-> l_pad.out[6] == alt.cmp2_out)
    else $error("comparator 2 output not routed");
  chk_pwm_channel_one_route: assert property (@(posedge clk) disable iff (!resetn) // R10
    alt.pwm_channel_one_en |-> l_pad.oe[5] && l_pad.out[5] == alt.pwm_channel_one)
    else $error("pwm_channel_one not routed");
  chk_cmp1_route: assert property (@(posedge clk) disable iff (!resetn) // R10
    alt.cmp1_en |-> l_pad.oe[2] && l_pad.out[2] == alt.cmp1_out)
    else $error("comparator 1 output not routed");
  chk_timer_route: assert property (@(posedge clk) // R11 R14
    disable iff (!resetn)
    alt.tio_en |-> g_pad.oe[3] && g_pad.out[3] == alt.tio)
    else $error("timer output not routed");
  chk_so_select: assert property (@(posedge clk) disable iff (!resetn) // R13
    serial_pin_select |-> g_pad.oe[4] && g_pad.out[4] == alt.so)
    else $error("serial data out not routed");
  chk_sk_unselected: assert property (@(posedge clk) // R13
    disable iff (!resetn)
    !serial_pin_select && g_cfg_ff[5] |-> g_pad.out[5] == g_data_ff[5])
    else $error("port bit overridden");
  chk_clock_pin: assert property (@(posedge clk) disable iff (!resetn) // R4
    g_pad.oe[7] && !g_pad.oe[6] && g_pad.out[7] == alt.osc_clk)
    else $error("clock pin or input pin wrong");
  chk_wake_inputs: assert property (@(posedge clk) disable iff (!resetn) // R3
    multi_input_wakeup == l_pin_in)
    else $error("wake-up input lost");
  chk_pin_read: assert property (@(posedge clk) disable iff (!resetn) // R2
    bus.rd && hit(bus.addr, `PIOC_ADDR_L_PIN) |=>
    rdata == {1'b0, $past(l_pin_in)})
    else $error("pin levels not read");
  chk_cfg_read: assert property (@(posedge clk) disable iff (!resetn) // R2
    bus.rd && hit(bus.addr, `PIOC_ADDR_G_CFG) |=> rdata == $past(g_cfg_ff))
    else $error("config read wrong");
  chk_d_write: assert property (@(posedge clk) disable iff (!resetn) // R9
    wr_d |=> d_out == $past(bus.wdata[3:0]))
    else $error("d port write lost");
endmodule
`default_nettype wire

// [bench/pioc_port_io_test.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pioc_cfg.svh"
module pioc_port_io_test;
  import pioc_pkg::*;
  logic clk;
  logic resetn;
  pioc_bus_t bus;
  logic [7:0] rdata;
  logic [6:0] l_pin_in;
  pioc_pad_t l_pad;
  logic [7:0] g_pin_in;
  pioc_pad_t g_pad;
  logic [3:0] d_out;
  pioc_alt_t alt;
  logic [6:0] wake;
  logic halt_req, idle_req, alt_ph, sel, sdi, tio, tcap, ext_int, cap;
  logic [7:0] v;
  int err_total;
  int checks;

  pioc_port_io dut_u (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .l_pin_in(l_pin_in), .l_pad(l_pad), .g_pin_in(g_pin_in), .g_pad(g_pad),
    .d_out(d_out), .alt(alt), .multi_input_wakeup(wake),
    .halt_req(halt_req), .idle_req(idle_req), .sk_alt_phase(alt_ph),
    .serial_pin_select(sel), .serial_data_in(sdi), .timer_io_pin(tio),
    .timer_capture_pin(tcap), .external_interrupt_pin(ext_int),
    .capture_input_pin(cap));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Strobe stands one cycle; effects are sampled just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic test_done;
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #20000;
    err_total++;
    test_done;
  end

  initial begin
    resetn = 1'b0;
    bus = '0;
    alt = '0;
    alt.so = 1'b1;
    l_pin_in = 7'h55;
    g_pin_in = 8'hA5;
    repeat (20) @(posedge clk);
    chk({4'h0, d_out}, 8'h0F);
    resetn <= 1'b1;
    #1;
    chk(l_pad.oe, 8'h00);
    chk(l_pad.pull | g_pad.pull, 8'h00);
    chk({2'b00, g_pad.oe[5:0]}, 8'h00);
    chk({g_pad.oe[7], 6'h00, g_pad.oe[6]}, 8'h80);
    for (int a = 0; a < 5; a++) begin
      if (a != 2) begin
        rd(8'(a), v);
        chk(v, 8'h00);
      end
    end
    wr(8'h01, 8'h0C);
    wr(8'h00, 8'h0A);
    chk({l_pad.oe[3:0], l_pad.pull[3:0]}, 8'hC2);
    chk({6'h00, l_pad.out[3:2]}, 8'h02);
    rd(8'h02, v);
    chk(v, 8'h55);
    rd(8'h05, v);
    chk(v, 8'hA5);
    chk({1'b0, wake}, 8'h55);
    chk({3'b000, sdi, tio, tcap, ext_int, cap}, 8'h07);
    wr(8'h03, 8'h80);
    chk({6'h00, halt_req, idle_req}, 8'h02);
    @(posedge clk);
    #1;
    chk({6'h00, halt_req, idle_req}, 8'h00);
    wr(8'h03, 8'h6A);
    chk({6'h00, halt_req, idle_req}, 8'h01);
    rd(8'h03, v);
    chk(v, 8'h2A);
    wr(8'h04, 8'hFF);
    chk({alt_ph, g_pad.oe[6], g_pad.oe[5:0]}, 8'hBF);
    wr(8'h04, 8'h3F);
    chk({alt_ph, sel, 4'h0, g_pad.out[5:4]}, 8'h02);
    wr(8'h07, 8'h08);
    chk({alt_ph, sel, 4'h0, g_pad.out[5:4]}, 8'h41);
    @(posedge clk);
    alt <= 13'h17F7; // All enables on; comparator 2 and serial out low
    #1;
    chk(l_pad.oe, 8'h6C);
    chk(l_pad.out, 8'h6E);
    chk(g_pad.out, 8'hAA);
    @(posedge clk);
    alt <= 13'h0820; // Only comparator 2 enabled, output high
    #1;
    chk(l_pad.oe, 8'h4C);
    chk(l_pad.out, 8'h4A);
    @(posedge clk);
    alt <= '0;
    wr(8'h20, 8'hFF);
    rd(8'h20, v);
    chk(v, 8'h00);
    rd(8'h00, v);
    chk(v, 8'h0A);
    wr(8'h06, 8'h05);
    chk({4'h0, d_out}, 8'h05);
    @(posedge clk);
    resetn <= 1'b0;
    #1;
    chk({4'h0, d_out}, 8'h0F);
    @(posedge clk);
    #1;
    chk(l_pad.oe | g_pad.pull, 8'h00);
    test_done;
  end
endmodule
`default_nettype wire
